// ---- hdl/gsdm_pkg.sv ----
// Purpose: Constants for the gateway status and diagnostic monitor
// Assumes: 100 MHz aclk, AXI4-Lite with 32-bit data
// Notes:   Byte offsets, field positions, reset values, flash timing
package gsdm_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_DIAG   = 5'h08;
  localparam logic [4:0] OFF_FAULT  = 5'h0c;
  localparam logic [4:0] OFF_ID     = 5'h10;
  // ==========================================================
  // Diagnostic bit positions
  localparam int DG_BUSOFF  = 0;
  localparam int DG_PASSIVE = 1;
  localparam int DG_INTCOMM = 2;
  localparam int DG_TXOVF   = 3;
  localparam int DG_RXOVF   = 4;
  localparam int DG_NULLADR = 5;
  localparam int DG_ADRCHG  = 6;
  localparam int DG_PGNLEN  = 7;
  localparam int DG_DM1     = 8;
  localparam int DG_TIMEOUT = 9;
  localparam int DG_HWFAULT = 10;
  localparam int DG_W       = 11;
  // Bits cleared by delivery acknowledge
  localparam logic [10:0] DG_ONESHOT = 11'h3dc;
  // ==========================================================
  // Reset values and identity
  localparam logic        CTRL_RST   = 1'b0;
  localparam logic [31:0] ID_VALUE   = 32'h0000_5a17; // Arbitrary value
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // ==========================================================
  // Flash timing: eight slots per pattern period
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_MS       = 200;
  localparam int SLOT_CYCLES   = SLOT_MS * (1000000 / CLK_PERIOD_NS);
  localparam logic [7:0] PAT_SINGLE = 8'h01;
  localparam logic [7:0] PAT_DOUBLE = 8'h05;
  localparam logic [7:0] PAT_FIELD  = 8'h0f;
endpackage

// ---- hdl/gsdm_monitor.sv ----
// Purpose: Indicators and diagnostic events of the fieldbus/CAN gateway
// Assumes: All inputs synchronous to aclk; event inputs are one-cycle pulses
// Notes:   Registers over AXI4-Lite; delivery acknowledged by W1C on DIAG
// ==========================================================
// Overview of operation
// - Link indicator lit while Ethernet link present
// - Activity indicator lit while packet moves
// - Gateway-state indicator follows ON/OFF state
// - CAN error indicator dark without CAN error
// - Error passive gives repeated single flash
// - Invalid source address gives double flash
// - Bus off lights CAN error indicator steadily
// - Bus-off diagnostic follows bus-off state
// - Error-passive diagnostic follows error-passive state
// - No CAN transmit or receive while bus off
// - No retransmission while error passive
// - Transmit overflow raised, frames dropped, cleared on delivery
// - Receive overflow raised, cleared on delivery
// - Internal communication error raised, cleared on delivery
// - Null address diagnostic held until new configuration
// - Address changed event cleared on delivery
// - PGN length mismatch one-shot, cleared on delivery
// - Changed DM1 one-shot, cleared on delivery
// - PGN timeout one-shot, cleared on delivery
// - Self-test hardware fault reported with code
// - Fieldbus error indicator flashes while diagnostics pending
module gsdm_monitor #(
  parameter int SLOT_CYCLES = gsdm_pkg::SLOT_CYCLES,
  parameter int FAULT_W     = 16
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [4:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [4:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Ethernet status
  input  wire logic               eth_link_up,
  input  wire logic               eth_packet_busy,
  // CAN controller state
  input  wire logic               can_error_passive,
  input  wire logic               can_bus_off,
  // Event pulses
  input  wire logic               tx_overflow,
  input  wire logic               rx_overflow,
  input  wire logic               internal_comm_error,
  input  wire logic               claim_null_address,
  input  wire logic               claim_new_address,
  input  wire logic               new_hw_config,
  input  wire logic               pgn_length_error,
  input  wire logic               dm1_changed,
  input  wire logic               pgn_timeout,
  // Self test
  input  wire logic               selftest_fault,
  input  wire logic [FAULT_W-1:0] selftest_code,
  // Indicators
  output logic                    eth_link_indicator,
  output logic                    activity_indicator,
  output logic                    gateway_state_indicator,
  output logic                    can_error_indicator,
  output logic                    fieldbus_error_indicator,
  // CAN datapath gating
  output logic                    can_tx_enable,
  output logic                    can_rx_enable,
  output logic                    can_retx_enable,
  output logic                    tx_frame_drop,
  output logic                    diag_pending
);

  // ==========================================================
  // Flash pattern state
  // Every code is a legal mode, so no default
  typedef enum logic [1:0] {
    GSDM_ERR_DARK   = 2'b00,
    GSDM_ERR_SINGLE = 2'b01,
    GSDM_ERR_DOUBLE = 2'b10,
    GSDM_ERR_STEADY = 2'b11
  } gsdm_err_mode_t;

  logic [31:0]              slot_cnt_reg;
  logic [31:0]              slot_cnt_next;
  logic [2:0]               slot_reg;
  logic [2:0]               slot_next;
  logic                     slot_end;
  gsdm_err_mode_t           err_mode;
  logic                     err_lit;

  // ==========================================================
  // Register state
  logic                     ctrl_on_reg;
  logic [gsdm_pkg::DG_W-1:0] diag_reg;
  logic [gsdm_pkg::DG_W-1:0] diag_next;
  logic [gsdm_pkg::DG_W-1:0] diag_set;
  logic [gsdm_pkg::DG_W-1:0] diag_ack;
  logic [FAULT_W-1:0]       fault_code_reg;
  logic                     passive_q_reg;

  // ==========================================================
  // Bus state
  // Write slots hold address and data until both have arrived
  logic                     aw_held_reg;
  logic [4:0]               aw_addr_reg;
  logic                     w_held_reg;
  logic [31:0]              w_data_reg;
  logic [3:0]               w_strb_reg;
  logic                     do_write;
  logic                     do_read;
  logic                     wr_hit;
  logic                     rd_hit;
  logic                     wr_ctrl;
  logic                     wr_diag;
  logic [31:0]              rd_word;
  logic [31:0]              status_word;

  // ==========================================================
  // Flash slot timing
  // Free-running, so both indicators flash in step
  assign slot_end      = (slot_cnt_reg == 32'(SLOT_CYCLES - 1));
  assign slot_cnt_next = slot_end ? 32'h0 : slot_cnt_reg + 32'h1;
  assign slot_next     = slot_end ? slot_reg + 3'h1 : slot_reg;

  // Bus off outranks invalid address, which outranks error passive
  assign err_mode = can_bus_off        ? GSDM_ERR_STEADY :
                    diag_reg[gsdm_pkg::DG_NULLADR] ? GSDM_ERR_DOUBLE :
                    can_error_passive  ? GSDM_ERR_SINGLE :
                                         GSDM_ERR_DARK;

  always_comb begin
    unique case (err_mode)
      GSDM_ERR_DARK:   err_lit = 1'b0;
      GSDM_ERR_SINGLE: err_lit = gsdm_pkg::PAT_SINGLE[slot_reg];
      GSDM_ERR_DOUBLE: err_lit = gsdm_pkg::PAT_DOUBLE[slot_reg];
      GSDM_ERR_STEADY: err_lit = 1'b1;
    endcase
  end

  // ==========================================================
  // Diagnostic events
  // Held inputs set their bit again every cycle
  always_comb begin
    diag_set = '0;
    diag_set[gsdm_pkg::DG_INTCOMM] = internal_comm_error;
    diag_set[gsdm_pkg::DG_TXOVF]   = tx_overflow;
    diag_set[gsdm_pkg::DG_RXOVF]   = rx_overflow;
    diag_set[gsdm_pkg::DG_ADRCHG]  = claim_new_address;
    diag_set[gsdm_pkg::DG_PGNLEN]  = pgn_length_error;
    diag_set[gsdm_pkg::DG_DM1]     = dm1_changed;
    diag_set[gsdm_pkg::DG_TIMEOUT] = pgn_timeout;
  end

  // Acknowledge touches only one-shot bits
  assign diag_ack = wr_diag ?
                    (w_data_reg[gsdm_pkg::DG_W-1:0] & gsdm_pkg::DG_ONESHOT) : '0;

  always_comb begin
    // Set wins over acknowledge so a repeat is never lost
    diag_next = (diag_reg & ~diag_ack) | diag_set;
    diag_next[gsdm_pkg::DG_BUSOFF]  = can_bus_off;
    diag_next[gsdm_pkg::DG_PASSIVE] = can_error_passive;
    // New configuration clears the null address, a fresh claim wins
    if (claim_null_address) begin
      diag_next[gsdm_pkg::DG_NULLADR] = 1'b1;
    end else if (new_hw_config) begin
      diag_next[gsdm_pkg::DG_NULLADR] = 1'b0;
    end
    if (selftest_fault) begin
      diag_next[gsdm_pkg::DG_HWFAULT] = 1'b1;
    end
  end

  // ==========================================================
  // Register decode
  assign do_write    = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign do_read     = s_axi_arvalid && s_axi_arready;
  // Writes with byte lane 0 off leave both registers alone
  assign wr_ctrl     = do_write && (aw_addr_reg == gsdm_pkg::OFF_CTRL) && w_strb_reg[0];
  assign wr_diag     = do_write && (aw_addr_reg == gsdm_pkg::OFF_DIAG) && w_strb_reg[0];
  assign wr_hit      = (aw_addr_reg == gsdm_pkg::OFF_CTRL) ||
                       (aw_addr_reg == gsdm_pkg::OFF_DIAG);
  assign rd_hit      = (s_axi_araddr == gsdm_pkg::OFF_CTRL)   ||
                       (s_axi_araddr == gsdm_pkg::OFF_STATUS) ||
                       (s_axi_araddr == gsdm_pkg::OFF_DIAG)   ||
                       (s_axi_araddr == gsdm_pkg::OFF_FAULT)  ||
                       (s_axi_araddr == gsdm_pkg::OFF_ID);
  // Error passive shows one cycle late, bus off live
  assign status_word = {23'h0, passive_q_reg, can_bus_off, fieldbus_error_indicator,
                        can_error_indicator, gateway_state_indicator,
                        activity_indicator, eth_link_indicator, diag_pending};
  // Unmapped reads give zero with an error response
  assign rd_word = (s_axi_araddr == gsdm_pkg::OFF_CTRL)   ? {31'h0, ctrl_on_reg} :
                   (s_axi_araddr == gsdm_pkg::OFF_STATUS) ? status_word :
                   (s_axi_araddr == gsdm_pkg::OFF_DIAG)   ? 32'(diag_reg) :
                   (s_axi_araddr == gsdm_pkg::OFF_FAULT)  ? 32'(fault_code_reg) :
                   (s_axi_araddr == gsdm_pkg::OFF_ID)     ? gsdm_pkg::ID_VALUE :
                                                            32'h0;

  // ==========================================================
  // AXI4-Lite write channel
  // Address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 5'h0;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gsdm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_reg <= 1'b0;
      end
      // Ready only while the holding slot is empty
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? gsdm_pkg::RESP_OKAY : gsdm_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // One read in flight; arready rests at least two cycles after each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= gsdm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !do_read;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? gsdm_pkg::RESP_OKAY : gsdm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control and diagnostic registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_on_reg    <= gsdm_pkg::CTRL_RST;
      diag_reg       <= '0;
      fault_code_reg <= '0;
      passive_q_reg  <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_on_reg <= w_data_reg[0];
      end
      diag_reg      <= diag_next;
      passive_q_reg <= can_error_passive;
      // First fault code is kept until reset
      if (selftest_fault && !diag_reg[gsdm_pkg::DG_HWFAULT]) begin
        fault_code_reg <= selftest_code;
      end
    end
  end

  // ==========================================================
  // Flash timebase
  // 32 bits cover slots of many seconds at 100 MHz
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_cnt_reg <= 32'h0;
      slot_reg     <= 3'h0;
    end else begin
      slot_cnt_reg <= slot_cnt_next;
      slot_reg     <= slot_next;
    end
  end

  // ==========================================================
  // Indicators and CAN gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eth_link_indicator       <= 1'b0;
      activity_indicator       <= 1'b0;
      gateway_state_indicator  <= 1'b0;
      can_error_indicator      <= 1'b0;
      fieldbus_error_indicator <= 1'b0;
      can_tx_enable            <= 1'b0;
      can_rx_enable            <= 1'b0;
      can_retx_enable          <= 1'b0;
      tx_frame_drop            <= 1'b0;
      diag_pending             <= 1'b0;
    end else begin
      eth_link_indicator       <= eth_link_up;
      activity_indicator       <= eth_packet_busy;
      gateway_state_indicator  <= ctrl_on_reg;
      can_error_indicator      <= err_lit;
      // Any pending diagnostic flashes the fieldbus error indicator
      fieldbus_error_indicator <= (|diag_reg) && gsdm_pkg::PAT_FIELD[slot_reg];
      // Bus off halts both directions
      can_tx_enable            <= !can_bus_off;
      can_rx_enable            <= !can_bus_off;
      // Error passive stops only the automatic retry
      can_retx_enable          <= !can_bus_off && !can_error_passive;
      // Overflowed frames are dropped, not retried
      tx_frame_drop            <= tx_overflow;
      diag_pending             <= |diag_reg;
    end
  end

endmodule

// ---- tb/gsdm_monitor_sva.sv ----
// Purpose: Port-level checks of the gateway monitor
// Assumes: Event inputs are one-cycle pulses
// Notes:   Indicators and gates lag their causes by one register stage
module gsdm_monitor_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Inputs watched
  input wire logic eth_link_up,
  input wire logic eth_packet_busy,
  input wire logic can_error_passive,
  input wire logic can_bus_off,
  input wire logic tx_overflow,
  input wire logic rx_overflow,
  // Outputs watched
  input wire logic eth_link_indicator,
  input wire logic activity_indicator,
  input wire logic can_error_indicator,
  input wire logic fieldbus_error_indicator,
  input wire logic can_tx_enable,
  input wire logic can_rx_enable,
  input wire logic can_retx_enable,
  input wire logic tx_frame_drop,
  input wire logic diag_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Sequences
  sequence s_event;
    tx_overflow || rx_overflow;
  endsequence
  // Three quiet cycles cover the register stage behind each indicator
  sequence s_quiet;
    (!can_bus_off && !can_error_passive && !diag_pending) [*3];
  endsequence
  // ==========================================================
  // Assertions
  chk_link_follows:
    assert property ($past(aresetn) |-> eth_link_indicator == $past(eth_link_up)) else $error("link indicator");
  chk_activity_follows:
    assert property ($past(aresetn) && $stable(eth_packet_busy) |-> activity_indicator == eth_packet_busy)
      else $error("activity indicator");
  chk_error_dark:
    assert property (s_quiet |-> !can_error_indicator) else $error("error indicator lit");
  chk_busoff_steady:
    assert property (can_bus_off [*3] |-> can_error_indicator) else $error("bus off not steady");
  chk_busoff_diag:
    assert property (can_bus_off [*2] |=> diag_pending) else $error("bus off not pending");
  chk_can_gate:
    assert property ($past(aresetn) |-> can_tx_enable == !$past(can_bus_off) && can_rx_enable == can_tx_enable)
      else $error("can gate");
  chk_retx_gate:
    assert property ($past(aresetn) |-> can_retx_enable == (!$past(can_bus_off) && !$past(can_error_passive)))
      else $error("retransmit gate");
  chk_drop_pulse:
    assert property (tx_overflow |=> tx_frame_drop) else $error("frame not dropped");
  chk_event_pending:
    assert property (s_event |-> ##2 diag_pending) else $error("event not pending");
  chk_field_dark:
    assert property (s_quiet |-> !fieldbus_error_indicator) else $error("fieldbus indicator lit");
endmodule

bind gsdm_monitor gsdm_monitor_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .eth_link_up(eth_link_up), .eth_packet_busy(eth_packet_busy),
  .can_error_passive(can_error_passive), .can_bus_off(can_bus_off), .tx_overflow(tx_overflow),
  .rx_overflow(rx_overflow), .eth_link_indicator(eth_link_indicator), .activity_indicator(activity_indicator),
  .can_error_indicator(can_error_indicator), .fieldbus_error_indicator(fieldbus_error_indicator),
  .can_tx_enable(can_tx_enable), .can_rx_enable(can_rx_enable), .can_retx_enable(can_retx_enable),
  .tx_frame_drop(tx_frame_drop), .diag_pending(diag_pending)
);

// ---- tb/gsdm_can_model.sv ----
// Purpose: CAN controller state seen by the monitor
// Assumes: mode bit0 error passive, bit1 bus off
// Notes:   Flags move just after an edge, like a real status register
module gsdm_can_model (
  // Clock and mode request
  input  wire logic       aclk,
  input  wire logic [1:0] mode,
  // Controller state
  output logic            can_error_passive = 1'b0,
  output logic            can_bus_off       = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge aclk) begin
    can_error_passive <= mode[0];
    can_bus_off       <= mode[1];
  end
endmodule

// ---- tb/gsdm_monitor_test.sv ----
// Purpose: Self-checking bench of the gateway monitor
// Assumes: SLOT_CYCLES 4, so one flash period is 32 cycles
// Notes:   Register traffic over AXI4-Lite tasks
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module gsdm_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        link = 1'b0, busy = 1'b0, hwf = 1'b0;
  logic        awr, wr, bv, arr, rv, pas, boff, li, ai, gi, ci, fi, txe, rxe, rte, drop, pend;
  logic [4:0]  awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0000_0000, rdata;
  logic [1:0]  bresp, rresp, mode = 2'h0;
  logic [8:0]  ev = 9'h000;
  logic [15:0] code = 16'h00b7;
  logic [3:0]  wstrb = 4'hf;
  int          num_errors = 0, tests_run = 0, cyc = 0;
  // ==========================================================
  // Design and far side
  gsdm_can_model i_can (.aclk(aclk), .mode(mode), .can_error_passive(pas), .can_bus_off(boff));
  gsdm_monitor #(.SLOT_CYCLES(4)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .eth_link_up(link), .eth_packet_busy(busy), .can_error_passive(pas), .can_bus_off(boff),
    .internal_comm_error(ev[0]), .tx_overflow(ev[1]), .rx_overflow(ev[2]), .claim_null_address(ev[3]),
    .claim_new_address(ev[4]), .pgn_length_error(ev[5]), .dm1_changed(ev[6]), .pgn_timeout(ev[7]),
    .new_hw_config(ev[8]), .selftest_fault(hwf), .selftest_code(code), .eth_link_indicator(li),
    .activity_indicator(ai), .gateway_state_indicator(gi), .can_error_indicator(ci),
    .fieldbus_error_indicator(fi), .can_tx_enable(txe), .can_rx_enable(rxe), .can_retx_enable(rte),
    .tx_frame_drop(drop), .diag_pending(pend));
  // ==========================================================
  // Clock, timeout and verdict
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Bus tasks; every valid holds until its own handshake edge
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv && br) begin
        br <= 1'b0;
        r = bresp;
      end
    end while (awv || wv || br);
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv && rr) begin
        rr <= 1'b0;
        d = rdata;
        r = rresp;
      end
    end while (arv || rr);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    `CHK(n, e, d)
    `CHK(n, gsdm_pkg::RESP_OKAY, r)
  endtask
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev <= 9'h000;
    repeat (3) @(posedge aclk);
  endtask
  // Counts lit cycles over one whole flash period
  task automatic lit(input logic sel, input logic [7:0] e, input string n);
    logic [7:0] c;
    c = 8'h00;
    repeat (8) @(posedge aclk);
    repeat (32) begin
      @(posedge aclk);
      c = c + {7'h00, sel ? fi : ci};
    end
    `CHK(n, e, c)
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(gsdm_pkg::OFF_ID, gsdm_pkg::ID_VALUE, "id");
    axi_rd(5'h14, d, r);
    `CHK("bad read", ({gsdm_pkg::RESP_SLVERR, 32'h0000_0000}), ({r, d}))
    axi_wr(5'h14, 32'h0000_0001, r);
    `CHK("bad write", gsdm_pkg::RESP_SLVERR, r)
    axi_wr(gsdm_pkg::OFF_CTRL, 32'h0000_0001, r);
    @(posedge aclk);
    `CHK("gateway on", 1'b1, gi)
    rd_chk(gsdm_pkg::OFF_STATUS, 32'h0000_0008, "status");
    axi_wr(gsdm_pkg::OFF_CTRL, 32'h0000_0000, r);
    @(posedge aclk);
    `CHK("gateway off", 1'b0, gi)
    wstrb <= 4'he;
    axi_wr(gsdm_pkg::OFF_CTRL, 32'h0000_0001, r);
    wstrb <= 4'hf;
    rd_chk(gsdm_pkg::OFF_CTRL, 32'h0000_0000, "lane off");
    link <= 1'b1;
    busy <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK("link act", 2'h3, ({li, ai}))
    link <= 1'b0;
    busy <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK("link act off", 2'h0, ({li, ai}))
    for (int i = 0; i < 8; i++) begin
      if (i == 3) continue;
      pulse(i);
      rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0001 << (i + 2), "event");
      axi_wr(gsdm_pkg::OFF_DIAG, 32'h0000_0001 << (i + 2), r);
      rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0000, "delivered");
    end
    // Acknowledge and a fresh overflow on one edge: the event survives
    pulse(1);
    fork
      axi_wr(gsdm_pkg::OFF_DIAG, 32'h0000_0008, r);
      begin
        @(posedge aclk);
        ev[1] <= 1'b1;
        @(posedge aclk);
        ev <= 9'h000;
      end
    join
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0008, "set wins");
    axi_wr(gsdm_pkg::OFF_DIAG, 32'h0000_0008, r);
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0000, "repeat gone");
    pulse(3);
    axi_wr(gsdm_pkg::OFF_DIAG, 32'h0000_0020, r);
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0020, "null kept");
    lit(1'b0, 8'h08, "double");
    lit(1'b1, 8'h10, "field");
    pulse(8);
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0000, "null gone");
    lit(1'b0, 8'h00, "err dark");
    lit(1'b1, 8'h00, "field dark");
    mode <= 2'h1;
    lit(1'b0, 8'h04, "single");
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0002, "passive");
    `CHK("retx", 1'b0, rte)
    mode <= 2'h2;
    repeat (3) @(posedge aclk);
    axi_wr(gsdm_pkg::OFF_DIAG, 32'h0000_0003, r);
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0001, "bus off");
    `CHK("off gate", 3'h1, ({txe, rxe, ci}))
    mode <= 2'h0;
    repeat (3) @(posedge aclk);
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0000, "bus on");
    `CHK("on gate", 3'h6, ({txe, rxe, ci}))
    hwf <= 1'b1;
    @(posedge aclk);
    hwf <= 1'b0;
    repeat (3) @(posedge aclk);
    rd_chk(gsdm_pkg::OFF_FAULT, 32'h0000_00b7, "fault code");
    rd_chk(gsdm_pkg::OFF_DIAG, 32'h0000_0400, "hw fault");
    stop_test();
  end
endmodule
